// ==== aci_pkg.sv ====
// Purpose: Shared constants for the codec init sequencer
// Assumes: 200 MHz clock, APB register access
// Notes:   Offsets are byte addresses
package aci_pkg;
    localparam int          CLK_MHZ        = 200;
    localparam int          LOCKOUT_US     = 1000;
    localparam int          MEMINIT_US     = 1000;
    localparam int          PLL_SETTLE_US  = 10000;
    localparam int          RST_MIN_NS     = 10;
    localparam int          CLK_PERIOD_NS  = 5;
    localparam int          LOCKOUT_CYC    = LOCKOUT_US * CLK_MHZ;
    localparam int          MEMINIT_CYC    = MEMINIT_US * CLK_MHZ;
    localparam int          PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
    localparam int          RST_MIN_CYC    = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W          = 22;
    localparam logic [11:0] OFS_SWRST      = 12'h004;
    localparam logic [11:0] OFS_PWRCTL     = 12'h008;
    localparam logic [11:0] OFS_HPCTL      = 12'h024;
    localparam logic [11:0] OFS_CMCTL      = 12'h028;
    localparam logic [11:0] OFS_HPSTAT     = 12'h02c;
    localparam logic [11:0] OFS_SPKCTL     = 12'h0b4;
    localparam logic [11:0] OFS_STATUS     = 12'h100;
    localparam int          BIT_SWRST      = 0;
    localparam int          BIT_PLLPD      = 3;
    localparam int          BIT_HPPWR      = 5;
    localparam int          BIT_CMSEL      = 6;
    localparam int          BIT_HPSHORT    = 0;
    localparam int          BIT_SPKPWR     = 1;
    localparam logic [7:0]  RST_PWRCTL     = 8'h08;
    localparam logic [7:0]  RST_ZERO       = 8'h00;
endpackage

// ==== aci_if.sv ====
// Purpose: Carries a lockout, memory-init or PLL timer's start and done
// Assumes: One clock domain
// Notes:   Used between top and timer
`timescale 1ns/10ps
interface aci_tmr_if;
    logic start;
    logic done;
    modport owner (output start, input done);
    modport timer (input start, output done);
endinterface

// ==== aci_timer.sv ====
// Purpose: One-shot cycle counter, done level after count
// Assumes: Synchronous active-high reset
// Notes:   Restarts on every start pulse
`timescale 1ns/10ps
module aci_timer
    import aci_pkg::*;
#(
    parameter int COUNT = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    aci_tmr_if.timer tmr
);
    logic [CNT_W-1:0] cnt;
    logic             running;
    wire              atEnd = (cnt == CNT_W'(COUNT - 1));

    always_ff @(posedge clk) begin
        if (rst || tmr.start) begin
            cnt     <= '0;
            running <= 1'b1;
            tmr.done <= 1'b0;
        end else if (running) begin
            cnt <= cnt + 1'b1;
            if (atEnd) begin
                running  <= 1'b0;
                tmr.done <= 1'b1;
            end
        end
    end
endmodule

// ==== aci_seq.sv ====
// Purpose: Codec reset and power sequencer with APB registers
// Assumes: Pin inputs synchronous to clk; APB master
// Notes:   Summary of operation
// Summary of operation
// - Reset pin low 10 ns resets device
// - Power-on detector resets device automatically
// - Software reset clears registers, not interface
// - Memory initialisation done within 1 ms
// - PLL clocks appear after 10 ms
// - Headphone power bit re-enables stage after latch
// - Headphone short powers driver down, reported
// - Speaker bit powers speaker stage independently
// - All blocks powered down after reset
// - Power down keeps register contents
// - PLL resets powered down
// - Common-mode select bit chooses 0.75/0.9 V
// - Select zero means 0.9 V default
`timescale 1ns/10ps
module aci_seq
    import aci_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Supplies, reset pin and headphone short detect
    input wire logic        digitalCoreSupplyOk,
    input wire logic        ioSupplyOk,
    input wire logic        resetPin_n,
    input wire logic        hpShortDetect,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic     [31:0] prdata,
    output logic            pready,
    output logic            pslverr,
    // Block controls
    output logic            devReady,
    output logic            codecClkOk,
    output logic            pllPowered,
    output logic            hpEnable,
    output logic            spkEnable,
    output logic            cmSel075
);
    logic       porSeen;
    logic [1:0] pinLowCnt;
    logic       pllPd;
    logic       hpPwr;
    logic       spkPwr;
    logic       cmSel;
    logic       hpShort;
    logic       swRstPulse;

    aci_tmr_if lockIf ();
    aci_tmr_if memIf ();
    aci_tmr_if pllIf ();

    // Reset sources
    wire suppliesUp = digitalCoreSupplyOk && ioSupplyOk;
    wire porEvent   = suppliesUp && !porSeen;
    wire pinReset   = suppliesUp && (pinLowCnt >= 2'(RST_MIN_CYC));
    wire regReset   = rst || porEvent || pinReset || swRstPulse;
    wire hwReset    = rst || porEvent || pinReset;

    // APB decode
    wire        apbWr    = psel && penable && pwrite;
    wire        apbRd    = psel && !pwrite && !penable;
    wire        selSw    = (paddr == OFS_SWRST);
    wire        selPwr   = (paddr == OFS_PWRCTL);
    wire        selHp    = (paddr == OFS_HPCTL);
    wire        selCm    = (paddr == OFS_CMCTL);
    wire        selHs    = (paddr == OFS_HPSTAT);
    wire        selSpk   = (paddr == OFS_SPKCTL);
    wire        selSt    = (paddr == OFS_STATUS);
    wire        mapped   = selSw | selPwr | selHp | selCm | selHs | selSpk | selSt;
    wire        hpSetReq = apbWr && selHp && pwdata[BIT_HPPWR];
    wire [31:0] rdMux    =
        selPwr ? {28'h0000000, pllPd, 3'h0} :
        selHp  ? {26'h0000000, hpPwr, 5'h00} :
        selCm  ? {25'h0000000, cmSel, 6'h00} :
        selHs  ? {31'h00000000, hpShort} :
        selSpk ? {30'h00000000, spkPwr, 1'b0} :
        selSt  ? {28'h0000000, codecClkOk, memIf.done, lockIf.done, devReady} :
                 32'h00000000;

    // Reset pin filter and power-on latch
    always_ff @(posedge clk) begin
        if (rst) begin
            porSeen   <= 1'b0;
            pinLowCnt <= 2'h0;
        end else begin
            porSeen <= suppliesUp ? 1'b1 : 1'b0;
            if (resetPin_n || !suppliesUp)
                pinLowCnt <= 2'h0;
            else if (pinLowCnt != 2'h3)
                pinLowCnt <= pinLowCnt + 2'h1;
        end
    end

    // Software reset pulse; interface unaffected
    always_ff @(posedge clk) begin
        if (hwReset)
            swRstPulse <= 1'b0;
        else
            swRstPulse <= apbWr && selSw && pwdata[BIT_SWRST];
    end

    // Control registers; power-down never changes settings
    always_ff @(posedge clk) begin
        if (regReset) begin
            pllPd  <= RST_PWRCTL[BIT_PLLPD];
            hpPwr  <= RST_ZERO[BIT_HPPWR];
            spkPwr <= RST_ZERO[BIT_SPKPWR];
            cmSel  <= RST_ZERO[BIT_CMSEL];
        end else if (apbWr) begin
            if (selPwr)
                pllPd <= pwdata[BIT_PLLPD];
            if (selHp)
                hpPwr <= pwdata[BIT_HPPWR];
            if (selSpk)
                spkPwr <= pwdata[BIT_SPKPWR];
            if (selCm)
                cmSel <= pwdata[BIT_CMSEL];
        end
    end

    // Headphone short latch; detection wins over re-enable
    always_ff @(posedge clk) begin
        if (regReset)
            hpShort <= 1'b0;
        else if (hpShortDetect)
            hpShort <= 1'b1;
        else if (hpSetReq)
            hpShort <= 1'b0;
    end

    // Timer starts
    assign lockIf.start = regReset;
    assign memIf.start  = regReset;
    assign pllIf.start  = regReset || pllPd;

    aci_timer #(.COUNT(LOCKOUT_CYC)) uLock (
        .clk (clk),
        .rst (rst),
        .tmr (lockIf)
    );
    aci_timer #(.COUNT(MEMINIT_CYC)) uMem (
        .clk (clk),
        .rst (rst),
        .tmr (memIf)
    );
    aci_timer #(.COUNT(PLL_SETTLE_CYC)) uPll (
        .clk (clk),
        .rst (rst),
        .tmr (pllIf)
    );

    // Registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            devReady   <= 1'b0;
            codecClkOk <= 1'b0;
            pllPowered <= 1'b0;
            hpEnable   <= 1'b0;
            spkEnable  <= 1'b0;
            cmSel075   <= 1'b0;
        end else begin
            devReady   <= lockIf.done && memIf.done && !regReset;
            codecClkOk <= pllIf.done && !pllPd && !regReset;
            pllPowered <= !pllPd;
            hpEnable   <= hpPwr && !hpShort && !hpShortDetect;
            spkEnable  <= spkPwr;
            cmSel075   <= cmSel;
        end
    end

    // APB slave, one wait-free access phase
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (apbRd)
                prdata <= rdMux;
        end
    end

    // Checks
    ready_after_lock_a: assert property (@(posedge clk) disable iff (rst)
        devReady |-> $past(lockIf.done) && $past(memIf.done))
        else $error("ready before lockout");
    reset_clears_ready_a: assert property (@(posedge clk) disable iff (rst)
        regReset |=> !devReady)
        else $error("ready during reset");
    short_kills_hp_a: assert property (@(posedge clk) disable iff (rst)
        hpShortDetect |=> !hpEnable)
        else $error("headphone on after short");
    blocks_off_reset_a: assert property (@(posedge clk) disable iff (rst)
        regReset |=> ##1 (!hpEnable && !spkEnable && !pllPowered))
        else $error("block powered after reset");
    pll_clk_wait_a: assert property (@(posedge clk) disable iff (rst)
        $rose(pllPowered) |-> !codecClkOk [*8])
        else $error("codec clock too early");
    spk_independent_a: assert property (@(posedge clk) disable iff (rst)
        (hpSetReq && !regReset) |=> $stable(spkPwr))
        else $error("speaker disturbed");
    cm_default_a: assert property (@(posedge clk) disable iff (rst)
        regReset |=> ##1 !cmSel075)
        else $error("common mode default wrong");
    pin_reset_a: assert property (@(posedge clk) disable iff (rst)
        (suppliesUp && !resetPin_n) [*3] |=> !hpPwr && !spkPwr)
        else $error("pin reset ignored");
    hp_reenable_a: assert property (@(posedge clk) disable iff (rst)
        (hpSetReq && !hpShortDetect && !regReset) |=> !hpShort && hpPwr)
        else $error("headphone not re-enabled");
    por_reset_a: assert property (@(posedge clk) disable iff (rst)
        $rose(suppliesUp) |=> ##1 !devReady && !hpEnable)
        else $error("power-on reset missing");
    sw_keeps_iface_a: assert property (@(posedge clk) disable iff (rst)
        (swRstPulse && psel && !penable) |=> pready)
        else $error("software reset hit interface");
    mem_init_time_a: assert property (@(posedge clk) disable iff (rst)
        $rose(memIf.done) |-> $past(lockIf.done) || lockIf.done)
        else $error("memory init timing");
    pd_keeps_cfg_a: assert property (@(posedge clk) disable iff (rst)
        (!apbWr && !regReset) |=> $stable(cmSel))
        else $error("setting changed");
    pll_reset_pd_a: assert property (@(posedge clk) disable iff (rst)
        regReset |=> pllPd)
        else $error("pll not powered down");
    cm_select_a: assert property (@(posedge clk) disable iff (rst)
        (apbWr && selCm && !regReset) |=> ##1 cmSel075 == $past(pwdata[BIT_CMSEL], 2))
        else $error("common mode select wrong");
    ready_one_cycle_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable) |=> pready)
        else $error("bus ready missing");
    err_unmapped_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && !mapped) |=> pslverr)
        else $error("unmapped access not flagged");
    sw_clears_cfg_a: assert property (@(posedge clk) disable iff (rst)
        swRstPulse |=> !cmSel && pllPd && !hpPwr && !spkPwr)
        else $error("software reset left settings");
    por_clears_cfg_a: assert property (@(posedge clk) disable iff (rst)
        porEvent |=> !cmSel && pllPd && !hpPwr && !spkPwr)
        else $error("power-on reset left settings");
    clk_needs_pll_a: assert property (@(posedge clk) disable iff (rst)
        codecClkOk |-> !$past(pllPd))
        else $error("codec clock without pll");
    pll_off_no_clk_a: assert property (@(posedge clk) disable iff (rst)
        pllPd |=> !codecClkOk)
        else $error("codec clock while pll down");
    hp_needs_power_a: assert property (@(posedge clk) disable iff (rst)
        hpEnable |-> $past(hpPwr) && !$past(hpShort))
        else $error("headphone on without power");
    short_sets_flag_a: assert property (@(posedge clk) disable iff (rst)
        (hpShortDetect && !regReset) |=> hpShort)
        else $error("short not reported");
    spk_follows_a: assert property (@(posedge clk) disable iff (rst)
        spkEnable |-> $past(spkPwr))
        else $error("speaker on without power");
    cm_output_a: assert property (@(posedge clk) disable iff (rst)
        cmSel075 |-> $past(cmSel))
        else $error("common mode output wrong");
    ready_needs_mem_a: assert property (@(posedge clk) disable iff (rst)
        !memIf.done |=> !devReady)
        else $error("ready before memory init");
endmodule

// ==== aci_host_model.sv ====
// Purpose: Host processor model, APB master
// Assumes: Registered slave ready
// Notes:   Bounded wait for ready
`timescale 1ns/10ps
module aci_host_model (
    // Clock
    input wire logic        clk,
    // Slave answer
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Request
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic     [11:0] paddr,
    output logic     [31:0] pwdata
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end

    // One transfer, held until ready or 16 cycles; audio clocks assumed running
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output bit ok);
        int n;
        ok  = 1'b0;
        rd  = 32'h00000000;
        err = 1'b0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                ok  = 1'b1;
                rd  = prdata;
                err = pslverr;
            end
        end
        // Released bus shows no stale data
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask
endmodule

// ==== audio_codec_init_sequencer_test.sv ====
// Purpose: Self-checking bench for the init sequencer
// Assumes: Counts too long to elapse in this run
// Notes:   Host model drives APB
`timescale 1ns/10ps
module audio_codec_init_sequencer_test;
    import aci_pkg::*;
    logic        clk, rst, coreOk, ioOk, resetPin_n, hpShort;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic        devReady, codecClkOk, pllPowered, hpEnable, spkEnable, cmSel075;
    int          fails, nChecks;
    logic [11:0] zeroRegs [4] = '{OFS_HPCTL, OFS_CMCTL, OFS_SPKCTL, OFS_HPSTAT};

    aci_seq i_dut (.clk(clk), .rst(rst), .digitalCoreSupplyOk(coreOk), .ioSupplyOk(ioOk),
        .resetPin_n(resetPin_n), .hpShortDetect(hpShort), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .devReady(devReady), .codecClkOk(codecClkOk),
        .pllPowered(pllPowered), .hpEnable(hpEnable), .spkEnable(spkEnable),
        .cmSel075(cmSel075));
    aci_host_model i_host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim();
        if (fails == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t mismatch seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
        bit ok;
        i_host.xfer(w, a, d, r, e, ok);
        if (!ok) begin
            fails++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        access(1'b1, a, d, r, e);
        cyc(2);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic        e;
        access(1'b0, a, 32'h00000000, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, experr});
    endtask

    function automatic logic [31:0] outs();
        return {26'h0, devReady, codecClkOk, pllPowered, hpEnable, spkEnable, cmSel075};
    endfunction

    initial begin
        cyc(50000);
        fails++;
        end_sim();
    end

    initial begin
        fails = 0;
        nChecks = 0;
        rst = 1'b1;
        coreOk = 1'b0;
        ioOk = 1'b0;
        resetPin_n = 1'b0;
        hpShort = 1'b0;
        cyc(6);
        rst <= 1'b0;
        coreOk <= 1'b1;
        ioOk <= 1'b1;
        cyc(2);
        resetPin_n <= 1'b1;
        cyc(2);
        check(outs(), 32'h0);
        rdchk(OFS_PWRCTL, {24'h0, RST_PWRCTL}, 1'b0);
        foreach (zeroRegs[i]) rdchk(zeroRegs[i], 32'h0, 1'b0);
        rdchk(OFS_STATUS, 32'h0, 1'b0);
        rdchk(12'h0fc, 32'h0, 1'b1);
        wr(OFS_PWRCTL, 32'h0);
        check(outs(), 32'h8);
        cyc(100);
        check({31'h0, codecClkOk}, 32'h0);
        wr(OFS_CMCTL, 32'h40);
        check({31'h0, cmSel075}, 32'h1);
        wr(OFS_SPKCTL, 32'h2);
        check({30'h0, hpEnable, spkEnable}, 32'h1);
        wr(OFS_HPCTL, 32'h20);
        hpShort <= 1'b1;
        cyc(1);
        hpShort <= 1'b0;
        cyc(2);
        check({30'h0, hpEnable, spkEnable}, 32'h1);
        rdchk(OFS_HPSTAT, 32'h1, 1'b0);
        wr(OFS_HPCTL, 32'h20);
        check({30'h0, hpEnable, spkEnable}, 32'h3);
        rdchk(OFS_HPSTAT, 32'h0, 1'b0);
        rdchk(OFS_CMCTL, 32'h40, 1'b0);
        wr(OFS_SPKCTL, 32'h0);
        wr(OFS_PWRCTL, 32'h8);
        check(outs(), 32'h5);
        rdchk(OFS_HPCTL, 32'h20, 1'b0);
        wr(OFS_SWRST, 32'h1);
        cyc(1);
        check(outs(), 32'h0);
        rdchk(OFS_SWRST, 32'h0, 1'b0);
        rdchk(OFS_PWRCTL, {24'h0, RST_PWRCTL}, 1'b0);
        rdchk(OFS_CMCTL, 32'h0, 1'b0);
        wr(OFS_CMCTL, 32'h40);
        resetPin_n <= 1'b0;
        cyc(1);
        resetPin_n <= 1'b1;
        cyc(2);
        check({31'h0, cmSel075}, 32'h1);
        resetPin_n <= 1'b0;
        cyc(2);
        resetPin_n <= 1'b1;
        cyc(3);
        check({31'h0, cmSel075}, 32'h0);
        wr(OFS_CMCTL, 32'h40);
        coreOk <= 1'b0;
        cyc(3);
        coreOk <= 1'b1;
        cyc(3);
        check(outs(), 32'h0);
        rdchk(OFS_CMCTL, 32'h0, 1'b0);
        end_sim();
    end
endmodule
